// file: hdl/bfs_cfg.svh
// Offsets, field positions, reset values and timing counts of the breaker failure unit
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// ****************
// Register offsets
// ****************
`define BFS_OFS_CTRL 8'h00
`define BFS_OFS_STATUS 8'h04
`define BFS_OFS_CMD 8'h08
`define BFS_OFS_SET0 8'h10
`define BFS_OFS_SET1 8'h14
`define BFS_OFS_SET2 8'h18
`define BFS_OFS_SET3 8'h1C

// ****************
// Control fields
// ****************
`define BFS_CTRL_EN 0
`define BFS_CTRL_SCH_LO 1
`define BFS_CTRL_SCH_HI 2
`define BFS_CTRL_TRG_LO 3
`define BFS_CTRL_TRG_HI 4
`define BFS_CTRL_SET_LO 5
`define BFS_CTRL_SET_HI 6
`define BFS_CTRL_RST 7'h00

// ****************
// Parameter set fields
// ****************
`define BFS_SET_TIME_LO 0
`define BFS_SET_TIME_HI 15
`define BFS_SET_THR_LO 16
`define BFS_SET_THR_HI 31
`define BFS_SET_RST 32'h0000_0064

// ****************
// Command and status fields
// ****************
`define BFS_CMD_LOCK_RST 0
`define BFS_ST_WAIT 0
`define BFS_ST_RUN 1
`define BFS_ST_ALARM 2
`define BFS_ST_LOCK 3
`define BFS_ST_REJ 4

// ****************
// Timing
// ****************
`define BFS_CLK_MHZ 125
`define BFS_TICK_US 1000
`define BFS_TICK_CYCLES (`BFS_TICK_US * `BFS_CLK_MHZ)

`endif

// file: hdl/bfs_pkg.sv
// Types of the breaker failure unit
package bfs_pkg;

	typedef enum logic [1:0] {
		BFS_SCH_CUR,
		BFS_SCH_POS,
		BFS_SCH_BOTH
	} bfs_scheme_type;

	typedef enum logic [1:0] {
		BFS_TRG_ALL,
		BFS_TRG_EXT,
		BFS_TRG_CUR,
		BFS_TRG_NONE
	} bfs_trig_type;

	typedef enum logic [1:0] {
		BFS_STANDBY,
		BFS_RUNNING,
		BFS_REJECTED,
		BFS_TRIPPED
	} bfs_state_type;

endpackage

// file: hdl/bfs_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module bfs_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} bfs_sync_type;

	bfs_sync_type s_r;
	bfs_sync_type s_nxt;

	always_comb begin
		s_nxt.meta = async_in;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.stable;
endmodule // bfs_sync
`default_nettype wire

// file: hdl/bfs_tick.sv
// Fixed-rate tick enable for the supervision timer
`timescale 1ns/100ps
`default_nettype none
module bfs_tick #(
	parameter int TICK_CYCLES = 125000
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	output logic tick
);
	localparam int CW = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} bfs_tick_type;

	bfs_tick_type s_r;
	bfs_tick_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt == CW'(TICK_CYCLES - 1)) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;
endmodule // bfs_tick
`default_nettype wire

// file: hdl/bfs_breaker_failure_unit.sv
// Breaker failure supervision unit with APB register access
// Operation
// - Scheme selects current only, position only, or both together.
// - Current scheme: failure if current not below threshold at timer expiry.
// - Position scheme: failure if indicators show no opening at timer expiry.
// - Combined scheme: failure only if current flows and breaker not open.
// - Any selected trigger starts timer; timer keeps running after trigger drops.
// - Timer expiry before open detection raises the failure trip output.
// - Open detection per scheme stops the supervision timer.
// - Open detected with triggers still active enters rejected state.
// - Rejected returns to standby once all triggers drop.
// - Lockout set with failure trip, latched until lockout reset acknowledges.
// - Trigger mode: all, external, current trip commands, or none.
// - Three extra trigger inputs ORed in, regardless of breaker assignment.
// - Supervision-only sources give no trip command, hence never trigger.
// - Triggers count only when stage enabled and not blocked.
// - Status: waiting for trigger, running, failure alarm, lockout, rejected.
// - Time and threshold from active set of four; scheme, mode global.
`timescale 1ns/100ps
`default_nettype none
`include "bfs_cfg.svh"
module bfs_breaker_failure_unit
	import bfs_pkg::*;
#(
	parameter int NSRC = 8,
	parameter int CUR_W = 16,
	parameter int TICK_CYCLES = `BFS_TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NSRC-1:0] trip_command,
	input wire logic [NSRC-1:0] src_assigned,
	input wire logic [NSRC-1:0] src_is_ext,
	input wire logic [NSRC-1:0] src_is_cur,
	input wire logic [NSRC-1:0] src_superv_only,
	input wire logic [2:0] extra_trigger_input,
	input wire logic block_in,
	input wire logic lockout_ack,
	input wire logic [CUR_W-1:0] cur_l1,
	input wire logic [CUR_W-1:0] cur_l2,
	input wire logic [CUR_W-1:0] cur_l3,
	input wire logic pos_open_pin,
	input wire logic pos_closed_pin,
	output logic failure_trip,
	output logic lockout,
	output logic st_waiting,
	output logic st_running,
	output logic st_rejected
);

	// ****************
	// State
	// ****************
	typedef struct packed {
		bfs_state_type state;
		logic [15:0] timer;
		logic lock;
		logic en;
		bfs_scheme_type scheme;
		bfs_trig_type trig;
		logic [1:0] set_sel;
		logic [3:0][31:0] sets;
		logic [31:0] rdata;
		logic err;
		logic out_wait;
		logic out_run;
		logic out_rej;
		logic out_trip;
	} bfs_unit_type;

	bfs_unit_type s_r;
	bfs_unit_type s_nxt;

	logic tick;
	logic [1:0] pos_sync;
	logic pos_open;
	logic [15:0] sup_time;
	logic [CUR_W-1:0] threshold;
	logic cur_flow;
	logic breaker_open;
	logic [NSRC-1:0] eligible;
	logic [NSRC-1:0] mode_mask;
	logic trig_any;
	logic setup_ph;
	logic access_wr;
	logic lock_clr;
	logic [31:0] status_word;

	bfs_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.tick(tick)
	);

	// Aux contacts come straight from the switchgear pins
	bfs_sync #(
		.WIDTH(2)
	) u_pos_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.async_in({pos_closed_pin, pos_open_pin}),
		.sync_out(pos_sync)
	);

	// ****************
	// Detection
	// ****************
	// Open only when both contacts agree; a stuck pair reads as not open
	assign pos_open = pos_sync[0] & ~pos_sync[1];

	// Set switch moves the threshold at once; a running timer keeps its load
	assign sup_time = s_r.sets[s_r.set_sel][`BFS_SET_TIME_HI:`BFS_SET_TIME_LO];
	assign threshold = CUR_W'(s_r.sets[s_r.set_sel][`BFS_SET_THR_HI:`BFS_SET_THR_LO]);

	assign cur_flow = (cur_l1 >= threshold) | (cur_l2 >= threshold)
		| (cur_l3 >= threshold);

	always_comb begin
		case (s_r.scheme)
			BFS_SCH_CUR: breaker_open = ~cur_flow;
			BFS_SCH_POS: breaker_open = pos_open;
			BFS_SCH_BOTH: breaker_open = ~cur_flow | pos_open;
			default: breaker_open = ~cur_flow;
		endcase
	end

	// ****************
	// Triggers
	// ****************
	assign eligible = trip_command & src_assigned & ~src_superv_only;

	always_comb begin
		case (s_r.trig)
			BFS_TRG_ALL: mode_mask = {NSRC{1'b1}};
			BFS_TRG_EXT: mode_mask = src_is_ext;
			BFS_TRG_CUR: mode_mask = src_is_cur;
			default: mode_mask = '0;
		endcase
	end

	assign trig_any = s_r.en & ~block_in
		& ((|(eligible & mode_mask)) | (|extra_trigger_input));

	// ****************
	// Bus decode
	// ****************
	// Reads have no side effects; CMD is write-only and reads as zero
	assign setup_ph = psel & ~penable;
	assign access_wr = psel & penable & pwrite;
	assign lock_clr = lockout_ack
		| (access_wr & (paddr == `BFS_OFS_CMD) & pwdata[`BFS_CMD_LOCK_RST]);

	always_comb begin
		status_word = '0;
		status_word[`BFS_ST_WAIT] = (s_r.state == BFS_STANDBY);
		status_word[`BFS_ST_RUN] = (s_r.state == BFS_RUNNING);
		status_word[`BFS_ST_ALARM] = (s_r.state == BFS_TRIPPED);
		status_word[`BFS_ST_LOCK] = s_r.lock;
		status_word[`BFS_ST_REJ] = (s_r.state == BFS_REJECTED);
	end

	// ****************
	// Next state
	// ****************
	always_comb begin
		s_nxt = s_r;

		case (s_r.state)
			BFS_STANDBY: begin
				// Loaded once, so a later set switch cannot stretch this run
				if (trig_any) begin
					s_nxt.state = BFS_RUNNING;
					s_nxt.timer = sup_time;
				end
			end
			BFS_RUNNING: begin
				// Trigger may drop here without stopping the timer
				if (breaker_open) begin
					s_nxt.state = trig_any ? BFS_REJECTED : BFS_STANDBY;
				end else if (s_r.timer == 16'h0000) begin
					s_nxt.state = BFS_TRIPPED;
				end else if (tick) begin
					s_nxt.timer = s_r.timer - 16'h0001;
				end
			end
			BFS_REJECTED: begin
				if (!trig_any) begin
					s_nxt.state = BFS_STANDBY;
				end
			end
			BFS_TRIPPED: begin
				// Trip held while triggers stay, so the upstream breaker sees it
				if (!trig_any) begin
					s_nxt.state = BFS_STANDBY;
				end
			end
			default: s_nxt.state = BFS_STANDBY;
		endcase

		// Disabled or blocked stage drops any running supervision
		if (!s_r.en || block_in) begin
			s_nxt.state = BFS_STANDBY;
		end

		// Setting the lockout wins over an acknowledge in the same cycle
		if (s_r.state == BFS_RUNNING && s_nxt.state == BFS_TRIPPED) begin
			s_nxt.lock = 1'b1;
		end else if (lock_clr) begin
			s_nxt.lock = 1'b0;
		end

		// Status pins decoded one cycle ahead so they leave straight from flip-flops
		s_nxt.out_wait = (s_nxt.state == BFS_STANDBY);
		s_nxt.out_run = (s_nxt.state == BFS_RUNNING);
		s_nxt.out_rej = (s_nxt.state == BFS_REJECTED);
		s_nxt.out_trip = (s_nxt.state == BFS_TRIPPED);

		if (access_wr) begin
			case (paddr)
				`BFS_OFS_CTRL: begin
					s_nxt.en = pwdata[`BFS_CTRL_EN];
					s_nxt.scheme = bfs_scheme_type'(pwdata[`BFS_CTRL_SCH_HI:`BFS_CTRL_SCH_LO]);
					s_nxt.trig = bfs_trig_type'(pwdata[`BFS_CTRL_TRG_HI:`BFS_CTRL_TRG_LO]);
					s_nxt.set_sel = pwdata[`BFS_CTRL_SET_HI:`BFS_CTRL_SET_LO];
				end
				`BFS_OFS_SET0: s_nxt.sets[0] = pwdata;
				`BFS_OFS_SET1: s_nxt.sets[1] = pwdata;
				`BFS_OFS_SET2: s_nxt.sets[2] = pwdata;
				`BFS_OFS_SET3: s_nxt.sets[3] = pwdata;
				default: s_nxt.sets = s_r.sets;
			endcase
		end

		// Read data and error are fixed in setup so the access needs no wait
		if (setup_ph) begin
			s_nxt.rdata = '0;
			s_nxt.err = 1'b0;
			case (paddr)
				`BFS_OFS_CTRL: begin
					s_nxt.rdata[`BFS_CTRL_EN] = s_r.en;
					s_nxt.rdata[`BFS_CTRL_SCH_HI:`BFS_CTRL_SCH_LO] = s_r.scheme;
					s_nxt.rdata[`BFS_CTRL_TRG_HI:`BFS_CTRL_TRG_LO] = s_r.trig;
					s_nxt.rdata[`BFS_CTRL_SET_HI:`BFS_CTRL_SET_LO] = s_r.set_sel;
				end
				`BFS_OFS_STATUS: s_nxt.rdata = status_word;
				`BFS_OFS_CMD: s_nxt.rdata = '0;
				`BFS_OFS_SET0: s_nxt.rdata = s_r.sets[0];
				`BFS_OFS_SET1: s_nxt.rdata = s_r.sets[1];
				`BFS_OFS_SET2: s_nxt.rdata = s_r.sets[2];
				`BFS_OFS_SET3: s_nxt.rdata = s_r.sets[3];
				default: s_nxt.err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_r.state <= BFS_STANDBY;
			s_r.timer <= 16'h0000;
			s_r.lock <= 1'b0;
			s_r.en <= 1'b0;
			s_r.scheme <= BFS_SCH_CUR;
			s_r.trig <= BFS_TRG_ALL;
			s_r.set_sel <= 2'h0;
			s_r.sets <= {4{`BFS_SET_RST}};
			s_r.rdata <= 32'h0000_0000;
			s_r.err <= 1'b0;
			s_r.out_wait <= 1'b1;
			s_r.out_run <= 1'b0;
			s_r.out_rej <= 1'b0;
			s_r.out_trip <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************
	// Outputs
	// ****************
	// Every access completes without wait states
	assign pready = 1'b1;
	assign prdata = s_r.rdata;
	assign pslverr = psel & penable & s_r.err;
	assign failure_trip = s_r.out_trip;
	assign lockout = s_r.lock;
	assign st_waiting = s_r.out_wait;
	assign st_running = s_r.out_run;
	assign st_rejected = s_r.out_rej;

endmodule // bfs_breaker_failure_unit
`default_nettype wire

// file: sim/bfs_breaker_failure_unit_chk.sv
// Port assertions of the breaker failure unit
`timescale 1ns/100ps
`default_nettype none
module bfs_breaker_failure_unit_chk #(
	parameter int NSRC = 8
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [NSRC-1:0] trip_command,
	input wire logic [NSRC-1:0] src_assigned,
	input wire logic [NSRC-1:0] src_superv_only,
	input wire logic [2:0] extra_trigger_input,
	input wire logic block_in,
	input wire logic lockout_ack,
	input wire logic failure_trip,
	input wire logic lockout,
	input wire logic st_waiting,
	input wire logic st_running,
	input wire logic st_rejected
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic trig_on;
	logic clr;
	// Over-approximates the mode mask, so only used where a start already happened
	assign trig_on = (|extra_trigger_input) || (|(trip_command & src_assigned & ~src_superv_only));
	assign clr = lockout_ack || (psel && penable && pwrite && paddr == 8'h08);
	sequence s_trip;
		$rose(failure_trip);
	endsequence
	a_trip_locks: assert property (s_trip |-> lockout)
		else $error("lockout missing at trip");
	a_lock_cause: assert property ($rose(lockout) |-> failure_trip)
		else $error("lockout without trip");
	a_trip_source: assert property (s_trip |-> $past(st_running))
		else $error("trip not from running");
	a_lock_holds: assert property (lockout && !clr |=> lockout)
		else $error("lockout dropped");
	a_ack_clears: assert property (lockout_ack && !st_running |=> !lockout)
		else $error("lockout not cleared");
	a_rej_stays: assert property (st_rejected && trig_on && !block_in |=> st_rejected)
		else $error("rejected left early");
	a_rej_exit: assert property (st_rejected && !trig_on |=> st_waiting)
		else $error("rejected not left");
	a_trip_stands: assert property (failure_trip && trig_on && !block_in |=> failure_trip)
		else $error("trip dropped");
	a_block_idle: assert property (block_in |=> st_waiting)
		else $error("blocked but active");
	a_one_state: assert property ($onehot({st_waiting, st_running, st_rejected, failure_trip}))
		else $error("status not one-hot");
	a_run_cause: assert property ($rose(st_running) |-> $past(trig_on && !block_in))
		else $error("run without trigger");
endmodule // bfs_breaker_failure_unit_chk
`default_nettype wire

// file: sim/bfs_breaker_model.sv
// Circuit breaker model: auxiliary contacts and phase currents
`timescale 1ns/100ps
`default_nettype none
module bfs_breaker_model (
	input wire logic clk_sys,
	input wire logic open_cmd,
	input wire logic stuck,
	input wire logic pos_bad,
	input wire logic [3:0] dly,
	output logic pos_open_pin,
	output logic pos_closed_pin,
	output logic [15:0] cur_l1,
	output logic [15:0] cur_l2,
	output logic [15:0] cur_l3
);
	logic [3:0] cnt = 4'h0;
	logic moved;
	// Saturates so a long open command cannot make the poles flicker
	always @(posedge clk_sys) cnt <= !open_cmd ? 4'h0 : (cnt == 4'hF) ? cnt : cnt + 4'h1;
	assign moved = open_cmd && cnt > dly;
	// Faulty contact keeps reporting closed
	assign pos_open_pin = moved && !pos_bad;
	assign pos_closed_pin = !pos_open_pin;
	// Welded pole keeps load flowing; only one phase exceeds the threshold
	assign cur_l1 = 16'h0000;
	assign cur_l2 = (moved && !stuck) ? 16'h0000 : 16'h0040;
	assign cur_l3 = (moved && !stuck) ? 16'h0000 : 16'h0008;
endmodule // bfs_breaker_model
`default_nettype wire

// file: sim/test_bfs_breaker_failure_unit.sv
// Testbench of the breaker failure unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, a); end end
module test_bfs_breaker_failure_unit import bfs_pkg::*;;
	logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, lockout_ack = 0, block_in = 0;
	logic open_cmd = 0, stuck = 0, pos_bad = 0, err, pready, pslverr, failure_trip, lockout;
	logic st_waiting, st_running, st_rejected, pos_open_pin, pos_closed_pin;
	logic [7:0] paddr = 0, trip_command = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [2:0] extra_trigger_input = 0;
	logic [3:0] dly = 0;
	logic [15:0] cur_l1, cur_l2, cur_l3;
	int err_count = 0, checks_done = 0, n;
	// Tick period in cycles and the short supervision time of set 1 in ticks
	localparam int TK = 4;
	localparam int LD = 3;
	always #4 clk_sys = ~clk_sys;
	bfs_breaker_failure_unit #(.TICK_CYCLES(TK)) bfs_breaker_failure_unit_i (.clk_sys, .rst_b,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trip_command,
		.src_assigned(8'h85), .src_is_ext(8'h11), .src_is_cur(8'h84), .src_superv_only(8'h80),
		.extra_trigger_input, .block_in, .lockout_ack, .cur_l1, .cur_l2, .cur_l3, .pos_open_pin,
		.pos_closed_pin, .failure_trip, .lockout, .st_waiting, .st_running, .st_rejected);
	bfs_breaker_model bfs_breaker_model_i (.clk_sys, .open_cmd, .stuck, .pos_bad, .dly,
		.pos_open_pin, .pos_closed_pin, .cur_l1, .cur_l2, .cur_l3);
	task automatic results;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic trial(input bfs_scheme_type s, input logic stk, input logic bad, input logic e);
		apb(1'b1, 8'h00, {25'h0, 2'h1, BFS_TRG_ALL, s, 1'b1});
		stuck <= stk;
		pos_bad <= bad;
		dly <= 4'h3 * s;
		extra_trigger_input <= 3'h1;
		open_cmd <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (st_rejected !== 1'b1 && failure_trip !== 1'b1 && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK("trip", e, failure_trip)
		// First tick comes 1 to TK cycles in; trip is seen one edge after it is taken
		`CHK("time", e, n >= (LD - 1) * TK + 3 && n <= LD * TK + 2)
		apb(1'b0, 8'h04, 32'h0);
		`CHK("status", e ? 32'hC : 32'h10, rd)
		extra_trigger_input <= 3'h0;
		open_cmd <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK("standby", 1'b1, st_waiting)
		`CHK("lock_kept", e, lockout)
		apb(1'b1, 8'h08, 32'h1);
		@(posedge clk_sys);
		`CHK("lock_clr", 1'b0, lockout)
	endtask
	task automatic start_chk(input logic [1:0] m, input logic [7:0] t, input logic [2:0] x,
			input logic blk, input logic e);
		apb(1'b1, 8'h00, {25'h0, 2'h1, m, BFS_SCH_CUR, 1'b1});
		open_cmd <= 1'b1;
		trip_command <= t;
		extra_trigger_input <= x;
		block_in <= blk;
		n = 0;
		repeat (3) begin
			@(posedge clk_sys);
			if (st_running === 1'b1) n++;
		end
		`CHK("start", e, n > 0)
		trip_command <= 8'h0;
		extra_trigger_input <= 3'h0;
		block_in <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		results();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		`CHK("ctrl_rst", 32'h0, rd)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("set_rst", 32'h64, rd)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, err)
		// Stage still disabled from reset: a trigger must not start it
		extra_trigger_input <= 3'h1;
		repeat (3) @(posedge clk_sys);
		`CHK("disabled", 1'b1, st_waiting)
		extra_trigger_input <= 3'h0;
		// Set 1 is short; a wrong set choice shows as a 100 tick delay
		apb(1'b1, 8'h14, 32'h0010_0003);
		trial(BFS_SCH_CUR, 1'b1, 1'b0, 1'b1);
		trial(BFS_SCH_CUR, 1'b0, 1'b1, 1'b0);
		trial(BFS_SCH_POS, 1'b1, 1'b0, 1'b0);
		trial(BFS_SCH_POS, 1'b0, 1'b1, 1'b1);
		trial(BFS_SCH_BOTH, 1'b1, 1'b0, 1'b0);
		trial(BFS_SCH_BOTH, 1'b0, 1'b1, 1'b0);
		// Short trigger pulse against a welded breaker
		stuck <= 1'b1;
		open_cmd <= 1'b1;
		extra_trigger_input <= 3'h4;
		@(posedge clk_sys);
		extra_trigger_input <= 3'h0;
		n = 0;
		while (lockout !== 1'b1 && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK("late_trip", 1'b1, lockout)
		apb(1'b0, 8'h04, 32'h0);
		`CHK("status_lock", 32'h9, rd)
		lockout_ack <= 1'b1;
		@(posedge clk_sys);
		lockout_ack <= 1'b0;
		@(posedge clk_sys);
		`CHK("ack", 1'b0, lockout)
		stuck <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 8; s += 2) begin
				n = (s == 6) ? 7 : s;
				start_chk(m[1:0], 8'h1 << n, 3'h0, 1'b0,
					(n == 0 && m < 2) || (n == 2 && (m == 0 || m == 2)));
			end
		end
		for (int i = 0; i < 3; i++) start_chk(BFS_TRG_NONE, 8'h0, 3'h1 << i, 1'b0, 1'b1);
		start_chk(BFS_TRG_ALL, 8'h1, 3'h1, 1'b1, 1'b0);
		results();
	end
endmodule // test_bfs_breaker_failure_unit
bind bfs_breaker_failure_unit bfs_breaker_failure_unit_chk #(.NSRC(NSRC)) chk_i (.clk_sys,
	.rst_b, .psel, .penable, .pwrite, .paddr, .trip_command, .src_assigned, .src_superv_only,
	.extra_trigger_input, .block_in, .lockout_ack, .failure_trip, .lockout, .st_waiting,
	.st_running, .st_rejected);
`default_nettype wire
